// *** verilog/fdlhc_pkg.sv ***
package fdlhc_pkg;

  // Register offsets on the parallel control port
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_MASK = 4'h2;
  localparam logic [3:0] ADDR_RX_INFO = 4'h3;
  localparam logic [3:0] ADDR_RX_CODE = 4'h4;
  localparam logic [3:0] ADDR_TX_INFO = 4'h6;
  localparam logic [3:0] ADDR_TX_CODE = 4'h7;

  // Control register fields
  localparam int CTL_RX_CODE_RESET = 7;
  localparam int CTL_RX_PACKET_RESET = 6;
  localparam int CTL_FLAG_IDLE_SEL = 5;
  localparam int CTL_TX_PACKET_RESET = 4;
  localparam int CTL_ABORT = 3;
  localparam int CTL_END_OF_MSG = 2;
  localparam int CTL_ZERO_STUFF_DEFEAT = 1;
  localparam int CTL_CHECK_DEFEAT = 0;

  // Status register fields and which of them latch
  localparam int STS_CODE_CHANGE = 7;
  localparam int STS_PACKET_END = 6;
  localparam int STS_PACKET_START = 5;
  localparam int STS_RX_HALF = 4;
  localparam int STS_RX_NOT_EMPTY = 3;
  localparam int STS_TX_HALF = 2;
  localparam int STS_TX_NOT_FULL = 1;
  localparam int STS_MSG_END = 0;
  localparam logic [7:0] STS_LATCHED_MASK = 8'hE1;

  // Transmit code register fields
  localparam int TXC_SEND = 7;
  localparam int TXC_ENABLE = 6;
  localparam int TXC_CODE_W = 6;

  // Transmitted patterns
  localparam logic [7:0] PAT_FLAG = 8'h7E;
  localparam logic [7:0] PAT_IDLE = 8'hFF;
  localparam logic [7:0] PAT_ABORT = 8'hFE;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } fdlhc_req_s;

  typedef struct packed {
    logic code_change;
    logic packet_end;
    logic packet_start;
    logic msg_end;
  } fdlhc_evt_s;

  typedef struct packed {
    logic rx_half;
    logic rx_not_empty;
    logic tx_half;
    logic tx_not_full;
  } fdlhc_lvl_s;

endpackage

// *** verilog/fdlhc_status_latch.sv ***
`timescale 1ns/100ps
module fdlhc_status_latch (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Events and live levels, already in status bit order
  input wire logic [7:0] event_i,
  input wire logic [7:0] live_i,
  // Host mask write
  input wire logic mask_wr_i,
  input wire logic [7:0] mask_i,
  // Views
  output logic [7:0] sticky_o,
  output logic [7:0] read_view_o
);

  logic [7:0] sticky;
  logic [7:0] shadow;
  logic [7:0] next_sticky;
  logic [7:0] next_shadow;
  logic [7:0] lat;

  assign lat = fdlhc_pkg::STS_LATCHED_MASK;

  always_comb begin
    next_sticky = sticky;
    next_shadow = shadow;
    if (mask_wr_i) begin
      next_shadow = (shadow & ~mask_i) | (sticky & mask_i);
      next_sticky = sticky & ~(mask_i & lat);
    end
    // Set wins over a clear in the same cycle
    next_sticky = (next_sticky | (event_i & lat));
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sticky <= fdlhc_pkg::RESET_BYTE;
      shadow <= fdlhc_pkg::RESET_BYTE;
    end else begin
      sticky <= next_sticky;
      shadow <= next_shadow;
    end
  end

  assign sticky_o = sticky;
  // Live bits never pass through the shadow, so a mask write cannot touch them
  assign read_view_o = (shadow & lat) | (live_i & ~lat);

endmodule // fdlhc_status_latch

// *** verilog/fdlhc_host_control.sv ***
// Contract
// - Latched bit sets, holds until read, clears; here it holds until a status mask write clears it
// - Real-time bits show present condition only
// - Mask write updates read view, clears latch
// - Mask write leaves real-time bits alone
// - Unmasked status event pulls interrupt low
// - Interrupt releases after causing bit read; here it releases at the clearing status mask write
// - Code written then send bit transmits it
// - Bit 7 rising resets code detector
// - Bit 6 rising resets receive packet logic
// - Bit 5 selects 7Eh or FFh idle
// - Bit 4 rising resets transmit packet, code
// - Bit 3 rising flushes FIFO, sends abort
// - End-of-message cleared after last byte sent
// - Bit 1 set disables zero insertion
// - Mask bit 1 enables, 0 masks interrupt
// - Code, packet end/start, message end latch
`timescale 1ns/100ps
module fdlhc_host_control (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Parallel control port, synchronous to clk_i
  input wire fdlhc_pkg::fdlhc_req_s req_i,
  output logic [7:0] rd_data_o,
  // Events and levels from the packet and code engines
  input wire fdlhc_pkg::fdlhc_evt_s evt_i,
  input wire fdlhc_pkg::fdlhc_lvl_s lvl_i,
  input wire logic [7:0] rx_packet_info_i,
  input wire logic [7:0] tx_packet_info_i,
  input wire logic [7:0] rx_code_i,
  input wire logic last_byte_sent_i,
  // Interrupt
  output logic int_n_o,
  // Controls to the engines
  output logic rx_code_reset_o,
  output logic rx_packet_reset_o,
  output logic tx_packet_reset_o,
  output logic tx_code_reset_o,
  output logic tx_fifo_flush_o,
  output logic tx_send_abort_o,
  output logic [7:0] tx_idle_pattern_o,
  output logic tx_end_of_message_o,
  output logic tx_zero_stuff_defeat_o,
  output logic tx_check_defeat_o,
  output logic controller_enable_o,
  output logic send_code_o,
  output logic [5:0] tx_code_o
);

  // Host-visible registers
  logic [7:0] ctl;
  logic [7:0] next_ctl;
  logic [7:0] imask;
  logic [7:0] next_imask;
  logic [7:0] txc;
  logic [7:0] next_txc;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic [7:0] pulses;
  logic [7:0] next_pulses;
  logic send_q;
  logic next_send_q;
  logic [7:0] sts_evt;
  logic [7:0] sts_live;
  logic [7:0] sts_sticky;
  logic [7:0] sts_view;
  logic sts_mask_wr;
  logic wr_ctl;
  logic wr_imask;
  logic wr_txc;
  logic [7:0] int_src;

  function automatic logic hit(input fdlhc_pkg::fdlhc_req_s r, input logic [3:0] a);
    hit = r.wr && (r.addr == a);
  endfunction

  function automatic logic rise(input logic [7:0] prev, input logic [7:0] now, input int b);
    rise = !prev[b] && now[b];
  endfunction

  // Status bits gathered in register order
  always_comb begin
    sts_evt = fdlhc_pkg::RESET_BYTE;
    sts_evt[fdlhc_pkg::STS_CODE_CHANGE] = evt_i.code_change;
    sts_evt[fdlhc_pkg::STS_PACKET_END] = evt_i.packet_end;
    sts_evt[fdlhc_pkg::STS_PACKET_START] = evt_i.packet_start;
    sts_evt[fdlhc_pkg::STS_MSG_END] = evt_i.msg_end;
    sts_live = fdlhc_pkg::RESET_BYTE;
    sts_live[fdlhc_pkg::STS_RX_HALF] = lvl_i.rx_half;
    sts_live[fdlhc_pkg::STS_RX_NOT_EMPTY] = lvl_i.rx_not_empty;
    sts_live[fdlhc_pkg::STS_TX_HALF] = lvl_i.tx_half;
    sts_live[fdlhc_pkg::STS_TX_NOT_FULL] = lvl_i.tx_not_full;
  end

  assign sts_mask_wr = hit(req_i, fdlhc_pkg::ADDR_STATUS);

  assign wr_ctl = hit(req_i, fdlhc_pkg::ADDR_CONTROL);
  assign wr_imask = hit(req_i, fdlhc_pkg::ADDR_MASK);
  assign wr_txc = hit(req_i, fdlhc_pkg::ADDR_TX_CODE);

  fdlhc_status_latch u_status (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .event_i(sts_evt),
    .live_i(sts_live),
    .mask_wr_i(sts_mask_wr),
    .mask_i(req_i.wdata),
    .sticky_o(sts_sticky),
    .read_view_o(sts_view)
  );

  // Register writes and read mux
  always_comb begin
    next_ctl = ctl;
    next_imask = imask;
    next_txc = txc;
    next_rdata = rdata;
    next_send_q = 1'b0;
    // A host write wins over the end-of-message clear
    if (wr_ctl) begin
      next_ctl = req_i.wdata;
    end else if (last_byte_sent_i) begin
      next_ctl[fdlhc_pkg::CTL_END_OF_MSG] = 1'b0;
    end
    if (wr_imask) begin
      next_imask = req_i.wdata;
    end
    // Send is a strobe; the stored bit is readback only
    if (wr_txc) begin
      next_txc = req_i.wdata;
      next_send_q = req_i.wdata[fdlhc_pkg::TXC_SEND];
    end else if (pulses[fdlhc_pkg::CTL_TX_PACKET_RESET]) begin
      next_txc[fdlhc_pkg::TXC_SEND] = 1'b0;
    end
    if (req_i.rd) begin
      if (req_i.addr == fdlhc_pkg::ADDR_CONTROL) begin
        next_rdata = ctl;
      end else if (req_i.addr == fdlhc_pkg::ADDR_STATUS) begin
        next_rdata = sts_view;
      end else if (req_i.addr == fdlhc_pkg::ADDR_MASK) begin
        next_rdata = imask;
      end else if (req_i.addr == fdlhc_pkg::ADDR_RX_INFO) begin
        next_rdata = rx_packet_info_i;
      end else if (req_i.addr == fdlhc_pkg::ADDR_RX_CODE) begin
        next_rdata = rx_code_i;
      end else if (req_i.addr == fdlhc_pkg::ADDR_TX_INFO) begin
        next_rdata = tx_packet_info_i;
      end else if (req_i.addr == fdlhc_pkg::ADDR_TX_CODE) begin
        next_rdata = txc;
      end else begin
        // Unmapped offsets read as zero
        next_rdata = fdlhc_pkg::RESET_BYTE;
      end
    end
  end

  // One-cycle pulses on 0-to-1 edges of control bits 7, 6, 4 and 3
  // Edge taken against the next value, so the pulse lines up with the register update
  always_comb begin
    next_pulses = fdlhc_pkg::RESET_BYTE;
    next_pulses[fdlhc_pkg::CTL_RX_CODE_RESET] =
      rise(ctl, next_ctl, fdlhc_pkg::CTL_RX_CODE_RESET);
    next_pulses[fdlhc_pkg::CTL_RX_PACKET_RESET] =
      rise(ctl, next_ctl, fdlhc_pkg::CTL_RX_PACKET_RESET);
    next_pulses[fdlhc_pkg::CTL_TX_PACKET_RESET] =
      rise(ctl, next_ctl, fdlhc_pkg::CTL_TX_PACKET_RESET);
    next_pulses[fdlhc_pkg::CTL_ABORT] = rise(ctl, next_ctl, fdlhc_pkg::CTL_ABORT);
  end

  // Plain synchronous reset; every register clears
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ctl <= fdlhc_pkg::RESET_BYTE;
      imask <= fdlhc_pkg::RESET_BYTE;
      txc <= fdlhc_pkg::RESET_BYTE;
      rdata <= fdlhc_pkg::RESET_BYTE;
      pulses <= fdlhc_pkg::RESET_BYTE;
      send_q <= 1'b0;
    end else begin
      ctl <= next_ctl;
      imask <= next_imask;
      txc <= next_txc;
      rdata <= next_rdata;
      pulses <= next_pulses;
      send_q <= next_send_q;
    end
  end

  // Read data is registered and holds until the next read
  assign rd_data_o = rdata;

  // Live bits can hold the line low too; a status mask write that clears the latched cause releases it
  assign int_src = (sts_sticky | sts_live) & imask;
  assign int_n_o = ~|int_src;

  // Reset and abort strobes are one cycle wide
  assign rx_code_reset_o = pulses[fdlhc_pkg::CTL_RX_CODE_RESET];
  assign rx_packet_reset_o = pulses[fdlhc_pkg::CTL_RX_PACKET_RESET];
  assign tx_packet_reset_o = pulses[fdlhc_pkg::CTL_TX_PACKET_RESET];
  assign tx_code_reset_o = pulses[fdlhc_pkg::CTL_TX_PACKET_RESET];
  assign tx_fifo_flush_o = pulses[fdlhc_pkg::CTL_ABORT];
  assign tx_send_abort_o = pulses[fdlhc_pkg::CTL_ABORT];
  assign tx_idle_pattern_o = ctl[fdlhc_pkg::CTL_FLAG_IDLE_SEL] ?
    fdlhc_pkg::PAT_IDLE : fdlhc_pkg::PAT_FLAG;
  assign tx_end_of_message_o = ctl[fdlhc_pkg::CTL_END_OF_MSG];
  assign tx_zero_stuff_defeat_o = ctl[fdlhc_pkg::CTL_ZERO_STUFF_DEFEAT];
  assign tx_check_defeat_o = ctl[fdlhc_pkg::CTL_CHECK_DEFEAT];
  assign controller_enable_o = txc[fdlhc_pkg::TXC_ENABLE];
  assign send_code_o = send_q & txc[fdlhc_pkg::TXC_ENABLE];
  assign tx_code_o = txc[fdlhc_pkg::TXC_CODE_W-1:0];

endmodule // fdlhc_host_control

// *** testbench/fdlhc_host_control_asserts.sv ***
`timescale 1ns/100ps
module fdlhc_host_control_asserts (
  // Watched ports
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire fdlhc_pkg::fdlhc_req_s req_i,
  input wire fdlhc_pkg::fdlhc_evt_s evt_i,
  input wire fdlhc_pkg::fdlhc_lvl_s lvl_i,
  input wire logic last_byte_sent_i,
  input wire logic int_n_o,
  input wire logic rx_code_reset_o,
  input wire logic rx_packet_reset_o,
  input wire logic tx_packet_reset_o,
  input wire logic tx_code_reset_o,
  input wire logic tx_fifo_flush_o,
  input wire logic tx_send_abort_o,
  input wire logic [7:0] tx_idle_pattern_o,
  input wire logic tx_end_of_message_o,
  input wire logic tx_zero_stuff_defeat_o,
  input wire logic tx_check_defeat_o
);
  logic cw;
  logic mw;
  logic [7:0] mask_q;
  assign cw = req_i.wr && req_i.addr == fdlhc_pkg::ADDR_CONTROL;
  assign mw = req_i.wr && req_i.addr == fdlhc_pkg::ADDR_MASK;
  // Own copy of the mask so interrupt checks do not lean on the design
  always_ff @(posedge clk_i) begin
    if (!rstn_i) mask_q <= 8'h00;
    else if (req_i.wr && req_i.addr == fdlhc_pkg::ADDR_MASK) mask_q <= req_i.wdata;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  idle_select_a: assert property (cw |=>
    tx_idle_pattern_o == ($past(req_i.wdata[5]) ? 8'hFF : 8'h7E)) else $error("idle pattern");
  ctl_levels_a: assert property (cw |=>
    {tx_zero_stuff_defeat_o, tx_check_defeat_o} == $past(req_i.wdata[1:0])) else $error("defeats");
  rx_code_rst_a: assert property (rx_code_reset_o |->
    $past(cw && req_i.wdata[7]) ##1 !rx_code_reset_o) else $error("code reset");
  rx_pkt_rst_a: assert property (rx_packet_reset_o |->
    $past(cw && req_i.wdata[6]) ##1 !rx_packet_reset_o) else $error("rx reset");
  tx_reset_pair_a: assert property ((tx_packet_reset_o || tx_code_reset_o) |->
    tx_packet_reset_o && tx_code_reset_o && $past(cw && req_i.wdata[4])) else $error("tx reset");
  abort_pair_a: assert property ((tx_fifo_flush_o || tx_send_abort_o) |->
    tx_fifo_flush_o && tx_send_abort_o && $past(cw && req_i.wdata[3])) else $error("abort");
  eom_clear_a: assert property (last_byte_sent_i && !cw |=> !tx_end_of_message_o)
    else $error("end of message");
  masked_quiet_a: assert property (mask_q == 8'h00 |-> int_n_o) else $error("masked int");
  event_int_a: assert property (mask_q[7] && evt_i.code_change && !mw |=> !int_n_o)
    else $error("int not raised");
  int_release_a: assert property ($rose(int_n_o) |->
    $past(req_i.wr) || $past(lvl_i) != 4'h0) else $error("int release");
endmodule // fdlhc_host_control_asserts
bind fdlhc_host_control fdlhc_host_control_asserts i_fdlhc_host_control_asserts (
  .clk_i, .rstn_i, .req_i, .evt_i, .lvl_i, .last_byte_sent_i, .int_n_o, .rx_code_reset_o,
  .rx_packet_reset_o, .tx_packet_reset_o, .tx_code_reset_o, .tx_fifo_flush_o, .tx_send_abort_o,
  .tx_idle_pattern_o, .tx_end_of_message_o, .tx_zero_stuff_defeat_o, .tx_check_defeat_o);

// *** testbench/fdlhc_host_model.sv ***
`timescale 1ns/100ps
module fdlhc_host_model (
  // Bus to the block
  input wire logic clk_i,
  input wire logic [7:0] rd_data_i,
  output fdlhc_pkg::fdlhc_req_s req_o
);
  initial req_o = '0;
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req_o.wr = 1'b1;
    req_o.addr = a;
    req_o.wdata = d;
    @(negedge clk_i);
    req_o.wr = 1'b0;
    // Released data inverted so a stale byte never looks valid
    req_o.wdata = ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk_i);
    req_o.rd = 1'b1;
    req_o.addr = a;
    @(negedge clk_i);
    req_o.rd = 1'b0;
    d = rd_data_i;
  endtask
  task automatic poll(input logic [3:0] a, input logic [7:0] m, output logic [7:0] d);
    wr(a, m);
    rd(a, d);
    wr(a, d & m);
  endtask
endmodule // fdlhc_host_model

// *** testbench/fdlhc_host_control_tb_top.sv ***
`timescale 1ns/100ps
module fdlhc_host_control_tb_top;
  fdlhc_pkg::fdlhc_req_s req;
  fdlhc_pkg::fdlhc_evt_s evt;
  fdlhc_pkg::fdlhc_lvl_s lvl;
  logic [7:0] rdd, idle, v;
  logic [5:0] code;
  logic clk_i, rstn_i, lbs, irq_n, rcr, rpr, tpr, tcr, fl, ab, eom, zs, cd, en, sc;
  int err_total, n_checks;
  fdlhc_host_control i_fdlhc_host_control (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req),
    .rd_data_o(rdd), .evt_i(evt), .lvl_i(lvl), .rx_packet_info_i(8'h5A),
    .tx_packet_info_i(8'hA5), .rx_code_i(8'h15), .last_byte_sent_i(lbs), .int_n_o(irq_n),
    .rx_code_reset_o(rcr), .rx_packet_reset_o(rpr), .tx_packet_reset_o(tpr),
    .tx_code_reset_o(tcr), .tx_fifo_flush_o(fl), .tx_send_abort_o(ab),
    .tx_idle_pattern_o(idle), .tx_end_of_message_o(eom), .tx_zero_stuff_defeat_o(zs),
    .tx_check_defeat_o(cd), .controller_enable_o(en), .send_code_o(sc), .tx_code_o(code));
  fdlhc_host_model i_fdlhc_host_model (.clk_i(clk_i), .rd_data_i(rdd), .req_o(req));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic t_ctrl;
    int b[4] = '{7, 6, 4, 3};
    logic [5:0] e[4] = '{6'h20, 6'h10, 6'h0C, 6'h03};
    for (int i = 0; i < 4; i++) begin
      i_fdlhc_host_model.wr(4'h0, 8'h01 << b[i]);
      chk("pulses", {2'b00, e[i]}, {2'b00, rcr, rpr, tpr, tcr, fl, ab});
      // Writing one over one must stay quiet
      i_fdlhc_host_model.wr(4'h0, 8'h01 << b[i]);
      chk("repeat", 8'h00, {2'b00, rcr, rpr, tpr, tcr, fl, ab});
      i_fdlhc_host_model.wr(4'h0, 8'h00);
    end
    $display("control edges done");
  endtask
  task automatic t_levels;
    i_fdlhc_host_model.wr(4'h0, 8'h27);
    chk("idle", 8'hFF, idle);
    chk("levels", 8'h07, {5'h00, eom, zs, cd});
    @(negedge clk_i) lbs = 1'b1;
    @(negedge clk_i) lbs = 1'b0;
    chk("eom", 8'h03, {5'h00, eom, zs, cd});
    i_fdlhc_host_model.wr(4'h0, 8'h00);
    chk("idle", 8'h7E, idle);
    $display("control levels done");
  endtask
  task automatic t_status;
    lvl = 4'b0001;
    @(negedge clk_i) evt = 4'b1111;
    @(negedge clk_i) evt = 4'b0000;
    chk("int", 8'h01, {7'h00, irq_n});
    i_fdlhc_host_model.wr(4'h2, 8'h80);
    chk("int", 8'h00, {7'h00, irq_n});
    i_fdlhc_host_model.poll(4'h1, 8'h80, v);
    chk("status", 8'h82, v);
    chk("int", 8'h01, {7'h00, irq_n});
    i_fdlhc_host_model.poll(4'h1, 8'h61, v);
    chk("status", 8'h63, v);
    lvl = 4'b0000;
    i_fdlhc_host_model.poll(4'h1, 8'hFF, v);
    chk("status", 8'h00, v);
    // Event while its mask bit is already set
    @(negedge clk_i) evt = 4'b1000;
    @(negedge clk_i) evt = 4'b0000;
    chk("int", 8'h00, {7'h00, irq_n});
    i_fdlhc_host_model.poll(4'h1, 8'h80, v);
    chk("status", 8'h80, v);
    chk("int", 8'h01, {7'h00, irq_n});
    $display("status done");
  endtask
  task automatic t_code;
    logic [3:0] a[7] = '{4'h3, 4'h4, 4'h6, 4'h5, 4'h0, 4'h2, 4'h7};
    logic [7:0] e[7] = '{8'h5A, 8'h15, 8'hA5, 8'h00, 8'h00, 8'h80, 8'hC5};
    i_fdlhc_host_model.wr(4'h7, 8'hC5);
    chk("code", 8'hC5, {sc, en, code});
    for (int i = 0; i < 7; i++) begin
      i_fdlhc_host_model.rd(a[i], v);
      chk("info", e[i], v);
    end
    // Transmit reset must drop a pending send bit
    i_fdlhc_host_model.wr(4'h0, 8'h10);
    chk("tx reset", 8'h0C, {2'b00, rcr, rpr, tpr, tcr, fl, ab});
    i_fdlhc_host_model.rd(4'h7, v);
    chk("send clear", 8'h45, v);
    $display("code done");
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // About 100 cycles of tests; twenty times that is a hang
  initial begin
    #20000;
    err_total++;
    conclude();
  end
  initial begin
    rstn_i = 1'b0;
    lbs = 1'b0;
    evt = '0;
    lvl = '0;
    repeat (12) @(posedge clk_i);
    @(negedge clk_i) rstn_i = 1'b1;
    i_fdlhc_host_model.wr(4'h0, 8'h00);
    t_ctrl();
    t_levels();
    t_status();
    t_code();
    conclude();
  end
endmodule // fdlhc_host_control_tb_top
